// *** word_clock_sync_selector.sv ***
// Word clock input qualification, reference selection and output clock.
`timescale 1ns/10ps
`include "wc_consts.svh"
module word_clock_sync_selector (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_word_clock_in,
    input  wire logic        i_pref_source_word,
    input  wire logic        i_auto_follow_clock_mode,
    input  wire logic [2:0]  i_host_rate,
    input  wire logic        i_single_speed_out,
    output logic             o_word_clock_out,
    output logic             o_word_clock_lock_indicator,
    output logic [1:0]       o_lock_status,
    output logic             o_auto_follow_source_status,
    output logic [11:0]      o_ref_period,
    output logic             o_ref_double_speed,
    output logic             o_master_mode,
    output logic             o_fallback_active
);
    wc_meter_if mif ();
    wc_gen_if   gif ();

    wc_period_meter u_meter (
        .i_clk           (i_clk),
        .i_rst_n         (i_rst_n),
        .i_word_clock_in (i_word_clock_in),
        .m               (mif.meter)
    );

    wc_clock_gen u_gen (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .g       (gif.gen)
    );

    wc_pkg::lock_state_t state;
    wc_pkg::lock_state_t next_state;
    logic [2:0]          good_cnt;
    logic                use_word;
    logic [11:0]         ref_period;
    logic                fallback;
    logic [2:0]          fallback_rate;
    logic [2:0]          host_rate_q;

    // Range check on the freshly measured period.
    wire [11:0] per = mif.period;
    wire in_ds = (per >= `WC_DS_MIN) && (per <= `WC_DS_MAX);
    wire in_ss = (per >= `WC_SS_MIN) && (per <= `WC_SS_MAX);
    wire good  = in_ds | in_ss;
    wire bad_edge = mif.new_period & ~good;
    wire good_edge = mif.new_period & good;
    wire drop  = bad_edge | mif.timeout;
    wire valid = (state == wc_pkg::lk_locked);

    // Reference selection needs all three conditions at once.
    wire sel_word = i_pref_source_word & i_auto_follow_clock_mode
                  & valid;

    always_comb
    begin
        next_state = state;
        case (state)
            wc_pkg::lk_idle:
                if (good_edge)
                    next_state = wc_pkg::lk_check;
            wc_pkg::lk_check:
                if (drop)
                    next_state = wc_pkg::lk_idle;
                else if (good_edge && good_cnt == `WC_LOCK_PERIODS - 3'h1)
                    next_state = wc_pkg::lk_locked;
            wc_pkg::lk_locked:
                if (drop)
                    next_state = wc_pkg::lk_lost;
            wc_pkg::lk_lost:
                next_state = wc_pkg::lk_idle;
            default:
                next_state = wc_pkg::lk_idle;
        endcase
    end

    // Nearest standard rate to the last reference, used after a loss.
    wire [11:0] rp = ref_period;
    wire [2:0] nearest =
        (rp >= `WC_SS_MIN)   ? ((rp >= `WC_MID_SS_HI) ? 3'(wc_pkg::rate_32k)
                              : (rp >= `WC_MID_SS_LO) ? 3'(wc_pkg::rate_44k1)
                              : 3'(wc_pkg::rate_48k))
      : (rp >= `WC_MID_DS)   ? 3'(wc_pkg::rate_88k2)
      : 3'(wc_pkg::rate_96k);

    wire lost_ref = (state == wc_pkg::lk_locked) & drop & use_word;
    wire host_chg = (i_host_rate != host_rate_q);

    wire [2:0] master_rate = fallback ? fallback_rate : i_host_rate;
    wire [11:0] master_per =
        (master_rate == 3'(wc_pkg::rate_32k))  ? `WC_PER_32K  :
        (master_rate == 3'(wc_pkg::rate_44k1)) ? `WC_PER_44K1 :
        (master_rate == 3'(wc_pkg::rate_88k2)) ? `WC_PER_88K2 :
        (master_rate == 3'(wc_pkg::rate_96k))  ? `WC_PER_96K  :
        `WC_PER_48K;

    // Slave mode copies the input period directly.
    wire [11:0] used_per = use_word ? ref_period : master_per;
    wire used_ds = (used_per < `WC_SS_MIN);
    // Doubling the period halves a double speed rate into 32 to 48 kHz.
    wire [11:0] out_per = (i_single_speed_out && used_ds)
                        ? (used_per << 1) : used_per;
    assign gif.period = out_per;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            state    <= wc_pkg::lk_idle;
            good_cnt <= 3'h0;
        end
        else
        begin
            state <= next_state;
            if (next_state != wc_pkg::lk_check)
                good_cnt <= 3'h0;
            else if (good_edge)
                good_cnt <= good_cnt + 3'h1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            ref_period <= `WC_PER_48K;
        else if (good_edge)
            ref_period <= per;
    end

    // A loss arriving with a host rate change still wins: fallback is set.
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            use_word      <= 1'b0;
            fallback      <= 1'b0;
            fallback_rate <= `WC_RATE_DEF;
            host_rate_q   <= `WC_RATE_DEF;
        end
        else
        begin
            use_word    <= sel_word & ~drop;
            host_rate_q <= i_host_rate;
            if (lost_ref)
            begin
                fallback      <= 1'b1;
                fallback_rate <= nearest;
            end
            else if (host_chg || sel_word)
                fallback <= 1'b0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_word_clock_lock_indicator <= 1'b0;
            o_lock_status               <= 2'h0;
            o_auto_follow_source_status <= 1'b0;
            o_ref_period                <= 12'h000;
            o_ref_double_speed          <= 1'b0;
            o_master_mode               <= 1'b1;
            o_fallback_active           <= 1'b0;
            o_word_clock_out            <= 1'b0;
        end
        else
        begin
            o_word_clock_lock_indicator <= valid;
            o_lock_status <= {use_word, valid & ~use_word};
            o_auto_follow_source_status <= valid;
            o_ref_period       <= valid ? ref_period : 12'h000;
            o_ref_double_speed <= valid & (ref_period < `WC_SS_MIN);
            o_master_mode      <= ~use_word;
            o_fallback_active  <= fallback;
            o_word_clock_out   <= gif.wc_out;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sel_needs_pref_a: assert property (
        use_word |-> $past(i_pref_source_word && i_auto_follow_clock_mode))
        else $error("reference used without preference and auto mode");

    range_gates_lock_a: assert property (
        (state == wc_pkg::lk_check && bad_edge) |=> state == wc_pkg::lk_idle)
        else $error("out of range period did not drop qualification");

    lock_led_a: assert property (
        valid |=> o_word_clock_lock_indicator)
        else $error("lock indicator not lit on valid input");

    source_status_a: assert property (
        o_auto_follow_source_status |-> $past(valid))
        else $error("source status shown without valid input");

    ref_capture_a: assert property (
        good_edge |=> ref_period == $past(per))
        else $error("measured period not captured");

    slave_period_a: assert property (
        (use_word && !i_single_speed_out) |-> gif.period == ref_period)
        else $error("slave output period differs from input");

    master_period_a: assert property (
        (!use_word && !fallback && !i_single_speed_out
         && i_host_rate == 3'(wc_pkg::rate_32k))
        |-> gif.period == `WC_PER_32K)
        else $error("master output period not host rate");

    loss_fallback_a: assert property (
        lost_ref |=> fallback && !use_word ##1 o_master_mode)
        else $error("no master fallback after reference loss");

    single_speed_a: assert property (
        i_single_speed_out |-> gif.period >= `WC_SS_MIN)
        else $error("single speed output above 48 kHz");

    // A stalled output clock lets this run up to the loss timeout; no
    // legal half period comes near it, even with the period doubled.
    logic [11:0] out_hold;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n || (o_word_clock_out != gif.wc_out))
            out_hold <= 12'h000;
        else if (out_hold != `WC_TIMEOUT)
            out_hold <= out_hold + `WC_PER_ONE;
    end

    out_active_a: assert property (
        out_hold < `WC_TIMEOUT)
        else $error("word clock output stalled");

    select_word_a: assert property (
        (sel_word && !drop) |=> use_word)
        else $error("valid preferred word clock not taken as reference");

    ds_accept_a: assert property (
        (state == wc_pkg::lk_idle && mif.new_period && in_ds)
        |=> state == wc_pkg::lk_check)
        else $error("double speed period not accepted");

    double_flag_a: assert property (
        (valid && ref_period < `WC_SS_MIN) |=> o_ref_double_speed)
        else $error("double speed input not reported");

    lock_status_a: assert property (
        valid |=> o_lock_status != 2'h0)
        else $error("lock status empty on valid input");

    led_off_a: assert property (
        !valid |=> !o_word_clock_lock_indicator)
        else $error("lock indicator lit without valid input");

    status_shown_a: assert property (
        valid |=> o_auto_follow_source_status)
        else $error("source status not shown on valid input");

    ref_shown_a: assert property (
        valid |=> o_ref_period == $past(ref_period))
        else $error("measured period not reported");

    master_flag_a: assert property (
        !use_word |=> o_master_mode)
        else $error("master flag low without word clock reference");

    timeout_drop_a: assert property (
        (valid && mif.timeout) |=> state == wc_pkg::lk_lost)
        else $error("missing input did not drop the lock");

    fallback_rate_a: assert property (
        (fallback && !use_word && !i_single_speed_out
         && fallback_rate == 3'(wc_pkg::rate_96k))
        |-> gif.period == `WC_PER_96K)
        else $error("fallback period not the standard rate");

    fallback_clear_a: assert property (
        (fallback && host_chg && !lost_ref) |=> !fallback)
        else $error("fallback kept after host rate change");

    slave_halved_a: assert property (
        (use_word && i_single_speed_out && ref_period < `WC_SS_MIN)
        |-> gif.period == {ref_period[10:0], 1'b0})
        else $error("double speed slave rate not halved");

    lost_idle_a: assert property (
        (state == wc_pkg::lk_lost) |=> state == wc_pkg::lk_idle)
        else $error("qualification did not restart after loss");

    c_lock: cover property (state == wc_pkg::lk_check
                            ##1 state == wc_pkg::lk_locked);
    c_timeout: cover property (valid && mif.timeout);
    c_slave: cover property ($rose(use_word));
    c_fallback: cover property ($rose(fallback));
    c_halved: cover property (i_single_speed_out && used_ds);
endmodule // word_clock_sync_selector

// *** wc_consts.svh ***
// Constants for the word clock synchronisation and selection block.
// Function
// - Use word clock as reference only if preferred, auto mode on, valid.
// - Accept single or double speed input and adapt without any setting.
// - Light the lock indicator and report lock or sync on valid input.
// - Report word clock as auto-follow source while input is valid.
// - Measure the reference frequency in hardware and expose the value.
// - Drive the word clock output continuously at the used sample rate.
// - In master mode output the rate requested by host software.
// - In slave mode output the frequency of the selected input.
// - On reference loss go master at the nearest standard sample rate.
// - Word clock is a square wave at the audio sample rate.
// - Single-speed output option keeps output in 32 to 48 kHz range.
`ifndef WC_CONSTS_SVH
`define WC_CONSTS_SVH

`define WC_PER_W        12
`define WC_CLK_HZ       100000000
`define WC_FS_32K       32000
`define WC_FS_44K1      44100
`define WC_FS_48K       48000
`define WC_FS_88K2      88200
`define WC_FS_96K       96000
`define WC_PER_32K      12'(`WC_CLK_HZ / `WC_FS_32K)
`define WC_PER_44K1     12'(`WC_CLK_HZ / `WC_FS_44K1)
`define WC_PER_48K      12'(`WC_CLK_HZ / `WC_FS_48K)
`define WC_PER_88K2     12'(`WC_CLK_HZ / `WC_FS_88K2)
`define WC_PER_96K      12'(`WC_CLK_HZ / `WC_FS_96K)
`define WC_DS_MIN       12'h3e8
`define WC_DS_MAX       12'h640
`define WC_SS_MIN       12'h7d0
`define WC_SS_MAX       12'hc80
`define WC_TIMEOUT      12'hd48
`define WC_MID_SS_LO    12'h880
`define WC_MID_SS_HI    12'ha88
`define WC_MID_DS       12'h440
`define WC_LOCK_PERIODS 3'h4
`define WC_PER_ONE      12'h001
`define WC_RATE_DEF     3'h2

`endif

// *** wc_pkg.sv ***
// Types shared by the word clock synchronisation block.
package wc_pkg;
    typedef enum logic [2:0] {
        rate_32k  = 3'h0,
        rate_44k1 = 3'h1,
        rate_48k  = 3'h2,
        rate_88k2 = 3'h3,
        rate_96k  = 3'h4
    } rate_t;

    typedef enum logic [1:0] {
        lk_idle   = 2'h0,
        lk_check  = 2'h1,
        lk_locked = 2'h3,
        lk_lost   = 2'h2
    } lock_state_t;
endpackage

// *** wc_links_if.sv ***
// Interfaces between the selector, the period meter and the clock generator.
`timescale 1ns/10ps
interface wc_meter_if;
    logic        new_period;
    logic        timeout;
    logic [11:0] period;
    modport meter (output new_period, output timeout, output period);
    modport ctrl  (input new_period, input timeout, input period);
endinterface

interface wc_gen_if;
    logic [11:0] period;
    logic        wc_out;
    modport gen  (input period, output wc_out);
    modport ctrl (output period, input wc_out);
endinterface

// *** wc_period_meter.sv ***
// Measures the word clock input period in system clock cycles.
`timescale 1ns/10ps
`include "wc_consts.svh"
module wc_period_meter (
    input  wire logic  i_clk,
    input  wire logic  i_rst_n,
    input  wire logic  i_word_clock_in,
    wc_meter_if.meter  m
);
    logic [2:0]  sync;
    logic [11:0] cnt;
    logic        new_period;
    logic        timeout;
    logic [11:0] period;

    // The pin passes two flops; the third stage only feeds edge detection.
    wire rise    = sync[1] & ~sync[2];
    wire at_lim  = (cnt == `WC_TIMEOUT);
    wire [11:0] cnt_inc = cnt + `WC_PER_ONE;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            sync       <= 3'h0;
            cnt        <= 12'h000;
            new_period <= 1'b0;
            timeout    <= 1'b0;
            period     <= 12'h000;
        end
        else
        begin
            sync       <= {sync[1:0], i_word_clock_in};
            new_period <= rise & ~at_lim;
            timeout    <= at_lim & ~timeout;
            if (rise)
            begin
                cnt    <= 12'h000;
                period <= cnt_inc;
            end
            else if (!at_lim)
                cnt <= cnt_inc;
        end
    end

    assign m.new_period = new_period;
    assign m.timeout    = timeout;
    assign m.period     = period;
endmodule // wc_period_meter

// *** wc_clock_gen.sv ***
// Square wave word clock generator with a period given in clock cycles.
`timescale 1ns/10ps
`include "wc_consts.svh"
module wc_clock_gen (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    wc_gen_if.gen     g
);
    logic [11:0] cnt;
    logic [11:0] cur_per;
    logic        wc;

    // A new period is taken only at wrap so the output never glitches.
    wire        wrap     = (cnt >= cur_per - `WC_PER_ONE);
    wire [11:0] next_cnt = wrap ? 12'h000 : cnt + `WC_PER_ONE;
    wire [11:0] half     = wrap ? (g.period >> 1) : (cur_per >> 1);

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            cnt     <= 12'h000;
            cur_per <= `WC_PER_48K;
            wc      <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            if (wrap)
                cur_per <= g.period;
            wc <= (next_cnt < half);
        end
    end

    assign g.wc_out = wc;
endmodule // wc_clock_gen

// *** wc_source_model.sv ***
// Model of an external studio device that masters the word clock line.
`timescale 1ns/10ps
module wc_source_model (
    input  wire logic        i_run,
    input  wire logic [31:0] i_period_ns,
    output logic             o_word_clock
);
    initial o_word_clock = 1'b0;

    // This device masters the input line; the block under test follows it
    // only while it is the selected reference and otherwise runs as master.
    // The line stands still at low level while it is stopped.
    always
    begin
        if (i_run === 1'b1)
        begin
            o_word_clock = 1'b1;
            #(i_period_ns / 2.0);
            o_word_clock = 1'b0;
            #(i_period_ns / 2.0);
        end
        else
        begin
            o_word_clock = 1'b0;
            @(i_run);
        end
    end
endmodule // wc_source_model

// *** test_word_clock_sync_selector.sv ***
// Testbench for the word clock synchronisation and selection block.
`timescale 1ns/10ps
module test_word_clock_sync_selector;
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        word_clock;
    logic        src_run = 1'b0;
    logic [31:0] src_ns = 32'h0;
    logic        pref = 1'b0;
    logic        auto_mode = 1'b0;
    logic [2:0]  host_rate = 3'h2;
    logic        single_out = 1'b0;
    logic        wc_out;
    logic        lock_ind;
    logic [1:0]  lock_status;
    logic        src_status;
    logic [11:0] ref_period;
    logic        double_speed;
    logic        master;
    logic        fallback;
    int          err_total = 0;
    int          comparisons = 0;
    logic [31:0] per;
    logic [31:0] hi;
    logic [31:0] fs_tab [5] = '{32'h7d00, 32'hac44, 32'hbb80, 32'h15888,
                                32'h17700};

    always #5 i_clk = ~i_clk;

    wc_source_model i_src (
        .i_run       (src_run),
        .i_period_ns (src_ns),
        .o_word_clock(word_clock)
    );

    word_clock_sync_selector i_dut (
        .i_clk                      (i_clk),
        .i_rst_n                    (i_rst_n),
        .i_word_clock_in            (word_clock),
        .i_pref_source_word         (pref),
        .i_auto_follow_clock_mode   (auto_mode),
        .i_host_rate                (host_rate),
        .i_single_speed_out         (single_out),
        .o_word_clock_out           (wc_out),
        .o_word_clock_lock_indicator(lock_ind),
        .o_lock_status              (lock_status),
        .o_auto_follow_source_status(src_status),
        .o_ref_period               (ref_period),
        .o_ref_double_speed         (double_speed),
        .o_master_mode              (master),
        .o_fallback_active          (fallback)
    );

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // Counts one full output period from a rising edge, and its high part.
    task automatic check_out(input string what, input logic [31:0] p);
        logic prev;
        int   n;
        per = 0;
        hi = 0;
        n = 0;
        prev = wc_out;
        while (!(wc_out === 1'b1 && prev === 1'b0) && n < 8000)
        begin
            prev = wc_out;
            @(posedge i_clk);
            #1;
            n++;
        end
        do
        begin
            if (wc_out === 1'b1)
                hi++;
            per++;
            prev = wc_out;
            @(posedge i_clk);
            #1;
        end while (!(wc_out === 1'b1 && prev === 1'b0) && per < 8000);
        @(negedge i_clk);
        check(what, p, per);
        check("high time", p >> 1, hi);
    endtask

    // Waiting on the design's own indicator keeps the bench free of
    // assumptions about how many edges qualification takes.
    task automatic wait_lock(input logic exp);
        int n;
        n = 0;
        while (lock_ind !== exp && n < 20000)
        begin
            cyc(1);
            n++;
        end
        cyc(4);
        check("lock indicator", 32'(exp), 32'(lock_ind));
    endtask

    task automatic wait_ref(input logic [31:0] p);
        int n;
        n = 0;
        while (32'(ref_period) !== p && n < 20000)
        begin
            cyc(1);
            n++;
        end
        cyc(4);
        check("ref period", p, 32'(ref_period));
    endtask

    task automatic close_out;
        $display("Comparisons %0d, errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #900000;
        err_total++;
        $display("[FAIL] run length expected finish seen timeout");
        close_out();
    end

    initial
    begin
        cyc(11);
        check("reset outputs", 32'h2, 32'({wc_out, lock_ind, lock_status,
              src_status, ref_period, double_speed, master, fallback}));
        cyc(1);
        i_rst_n = 1'b1;
        pref = 1'b1;
        auto_mode = 1'b1;
        src_ns = 32'h515e;
        src_run = 1'b1;
        wait_lock(1'b1);
        wait_ref(32'h823);
        check("lock status", 32'h2, 32'(lock_status));
        check("auto source", 32'h1, 32'(src_status));
        check("double speed", 32'h0, 32'(double_speed));
        check("master mode", 32'h0, 32'(master));
        check_out("slave period", 32'h823);
        for (int k = 1; k < 4; k++)
        begin
            {pref, auto_mode} = 2'(k);
            cyc(4);
            check("master mode", 32'(k != 3), 32'(master));
            check("lock status", k == 3 ? 32'h2 : 32'h1,
                  32'(lock_status));
            check("auto source", 32'h1, 32'(src_status));
        end
        src_ns = 32'h588e;
        wait_ref(32'h8db);
        check_out("slave period", 32'h8db);
        src_run = 1'b0;
        wait_lock(1'b0);
        check("master mode", 32'h1, 32'(master));
        check("fallback", 32'h1, 32'(fallback));
        check("status", 32'h0, 32'({lock_status, src_status}));
        check("ref cleared", 32'h0, 32'(ref_period));
        check_out("fallback period", 32'h8db);
        src_ns = 32'h28aa;
        src_run = 1'b1;
        wait_lock(1'b1);
        wait_ref(32'h411);
        check("double speed", 32'h1, 32'(double_speed));
        check("reselected", 32'h0, 32'({master, fallback}));
        check_out("slave period", 32'h411);
        single_out = 1'b1;
        cyc(4);
        check_out("single speed period", 32'h822);
        single_out = 1'b0;
        src_ns = 32'h7d;
        wait_lock(1'b0);
        cyc(3000);
        check("fast input lock", 32'h0, 32'(lock_ind));
        check("fast input source", 32'h0, 32'(src_status));
        check("fallback", 32'h1, 32'(fallback));
        src_run = 1'b0;
        for (int r = 0; r < 5; r++)
        begin
            host_rate = 3'(r);
            cyc(4);
            check_out("master period", 32'h5f5e100 / fs_tab[r]);
        end
        check("fallback cleared", 32'h0, 32'(fallback));
        check("master mode", 32'h1, 32'(master));
        close_out();
    end
endmodule // test_word_clock_sync_selector
